// *** design/pio_pkg.sv ***
// Constants and carrier types for the parallel I/O port block.
// Assumes a CPU core on ref_clk issuing file reads/writes and direction loads.
// Functional notes
// R1 - First port: low four bits, upper read zero
// R2 - Second port: full eight-bit I/O
// R3 - Third port I/O, or storage on smallest variant
// R4 - Fourth port I/O only on largest variant
// R5 - Fifth port high nibble, low reads zero
// R6 - Direction load takes working register value
// R7 - Direction one is input, zero drives latch
// R8 - Port reads return sampled pin levels
// R9 - Direction write-only, all ones on resets
// R10 - Board holds inputs stable until read
// R11 - Latches hold until port rewritten
// R12 - Direction selectable per individual pin
// R13 - Latches undefined at power-on, kept otherwise
// R14 - Port writes update latch even as input
package pio_pkg;
  // ==========================================
  // Register file offsets
  localparam logic [4:0] PIO_ADDR_A = 5'h05;
  localparam logic [4:0] PIO_ADDR_B = 5'h06;
  localparam logic [4:0] PIO_ADDR_C = 5'h07;
  localparam logic [4:0] PIO_ADDR_D = 5'h08;
  localparam logic [4:0] PIO_ADDR_E = 5'h09;
  localparam int PIO_NPORT = 5;
  // Implemented-bit masks per port
  localparam logic [7:0] PIO_MASK_A = 8'h0F;
  localparam logic [7:0] PIO_MASK_FULL = 8'hFF;
  localparam logic [7:0] PIO_MASK_E = 8'hF0;
  localparam logic [7:0] PIO_DIR_RST = 8'hFF;
  localparam logic [7:0] PIO_LATCH_POR = 8'h00;
  // Variants: 0 smallest, 1 middle, 3 largest
  typedef enum logic [1:0] {
    PIO_VAR_SMALL = 2'h0,
    PIO_VAR_MID = 2'h1,
    PIO_VAR_LARGE = 2'h3
  } pio_variant_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic dir_ld;
    logic [2:0] dir_sel;
  } pio_req_t;
  typedef struct packed {
    logic [PIO_NPORT-1:0][7:0] latch;
    logic [PIO_NPORT-1:0][7:0] dir;
    logic [7:0] rdata;
    logic rvalid;
  } pio_state_t;
endpackage

// *** design/pio_sync.sv ***
// Three-stage pin filter: value changes when stages two and three agree.
// Assumes asynchronous pin inputs; one instance per 8-bit group.
`timescale 1ns/100ps
module pio_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] raw,
  output logic [7:0] level
);
  import pio_pkg::*;
  // ==========================================
  // Filter state
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lv;
  } pio_sync_st_t;
  pio_sync_st_t st_q, st_d;
  logic [7:0] agree;
  always_comb begin
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Per-bit update only where two and three agree
    agree = st_q.s2 ~^ st_q.s3;
    st_d.lv = (st_q.lv & ~agree) | (st_q.s2 & agree);
    if (rst) begin
      st_d.lv = PIO_LATCH_POR;
    end
  end
  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end
  assign level = st_q.lv;
endmodule

// *** design/pio_top.sv ***
// Parallel I/O ports: five port registers, write-only direction groups.
// Assumes the core presents one file access or direction load per cycle.
`timescale 1ns/100ps
module pio_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire pio_pkg::pio_variant_t variant,
  input wire pio_pkg::pio_req_t req,
  input wire logic [7:0] wreg,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic gpr_hit,
  input wire logic [39:0] pin_in,
  output logic [39:0] pin_out,
  output logic [39:0] pin_oe_n
);
  import pio_pkg::*;
  // ==========================================
  // State
  pio_state_t st_q, st_d;
  // Views of the state for the pin drive and the checks
  logic [PIO_NPORT-1:0][7:0] latch_q, dir_q, pin_lv;

  function automatic logic [7:0] port_mask(input int idx, input pio_variant_t v);
    logic [7:0] m;
    m = 8'h00;
    if (idx == 0) begin
      m = PIO_MASK_A;
    end else if (idx == 1) begin
      m = PIO_MASK_FULL;
    end else if (idx == 2) begin
      m = (v != PIO_VAR_SMALL) ? PIO_MASK_FULL : 8'h00;
    end else if (idx == 3) begin
      m = (v == PIO_VAR_LARGE) ? PIO_MASK_FULL : 8'h00;
    end else begin
      m = (v == PIO_VAR_LARGE) ? PIO_MASK_E : 8'h00;
    end
    return m;
  endfunction

  function automatic int addr_idx(input logic [4:0] a);
    int i;
    i = -1;
    if (a == PIO_ADDR_A) begin
      i = 0;
    end else if (a == PIO_ADDR_B) begin
      i = 1;
    end else if (a == PIO_ADDR_C) begin
      i = 2;
    end else if (a == PIO_ADDR_D) begin
      i = 3;
    end else if (a == PIO_ADDR_E) begin
      i = 4;
    end
    return i;
  endfunction

  // ==========================================
  // Pin synchronisers
  for (genvar g = 0; g < PIO_NPORT; g++) begin : g_sync
    pio_sync u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .raw(pin_in[g*8 +: 8]),
      .level(pin_lv[g])
    );
  end

  // ==========================================
  // Next state
  always_comb begin
    int k;
    logic [7:0] m;
    k = addr_idx(req.addr);
    m = 8'h00;
    st_d = st_q;
    st_d.rvalid = 1'b0;
    gpr_hit = 1'b0;
    for (int i = 0; i < PIO_NPORT; i++) begin
      m = port_mask(i, variant);
      // R11 latch holds otherwise
      // R14 write lands regardless of direction
      if (req.wr && k == i) begin
        st_d.latch[i] = (m == 8'h00) ? req.wdata : (req.wdata & m);
      end
      // R6 load from working register
      // R12 one bit per pin
      if (req.dir_ld && int'(req.dir_sel) == i) begin
        st_d.dir[i] = wreg | ~m;
      end
    end
    if (req.rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'h00;
      if (k >= 0) begin
        m = port_mask(k, variant);
        // R3 R4 R5 storage fallback
        if (m == 8'h00) begin
          gpr_hit = 1'b1;
          st_d.rdata = st_q.latch[k];
        end else begin
          // R8 pins, masked to implemented bits
          // R1 R2 R5 unused bits zero
          st_d.rdata = pin_lv[k] & m;
        end
      end
    end
    // R9 directions forced to inputs
    if (rst) begin
      st_d.dir = {PIO_NPORT{PIO_DIR_RST}};
      st_d.rdata = 8'h00;
      st_d.rvalid = 1'b0;
      gpr_hit = 1'b0;
      // R13 latches kept except on power-on
      // Writes seen during reset are not taken
      st_d.latch = por ? {PIO_NPORT{PIO_LATCH_POR}} : st_q.latch;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  // ==========================================
  // Pin drive
  // R7 one is input, zero drives latch
  always_comb begin
    for (int i = 0; i < PIO_NPORT; i++) begin
      pin_out[i*8 +: 8] = latch_q[i] & ~dir_q[i];
      pin_oe_n[i*8 +: 8] = dir_q[i];
    end
  end
  assign latch_q = st_q.latch;
  assign dir_q = st_q.dir;
  assign rdata = st_q.rdata;
  assign rvalid = st_q.rvalid;

  // ==========================================
  // Checks
  property p_dir_reset;
    @(posedge ref_clk) rst |=> (dir_q == {PIO_NPORT{PIO_DIR_RST}});
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir not ones after reset"); // R9

  property p_dir_load;
    @(posedge ref_clk) disable iff (rst)
      (req.dir_ld && req.dir_sel == 3'h1) |=> (dir_q[1] == $past(wreg));
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("dir load mismatch"); // R6

  property p_oe;
    @(posedge ref_clk) disable iff (rst)
      (req.dir_ld && req.dir_sel == 3'h2 && variant != PIO_VAR_SMALL)
        |=> pin_oe_n[23:16] == $past(wreg);
  endproperty
  a_oe: assert property (p_oe) else $error("enable not from dir"); // R7

  property p_drive;
    @(posedge ref_clk) disable iff (rst)
      (req.wr && req.addr == PIO_ADDR_B && !req.dir_ld)
        |=> pin_out[15:8] == ($past(req.wdata) & ~dir_q[1]);
  endproperty
  a_drive: assert property (p_drive) else $error("driven value wrong"); // R12

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
      !(req.wr && req.addr == PIO_ADDR_B) |=> $stable(latch_q[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed"); // R11

  property p_wr_input;
    @(posedge ref_clk) disable iff (rst)
      (req.wr && req.addr == PIO_ADDR_B) |=> latch_q[1] == $past(req.wdata);
  endproperty
  a_wr_input: assert property (p_wr_input) else $error("latch write lost"); // R14

  property p_a_upper;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_A) |=> rdata[7:4] == 4'h0;
  endproperty
  a_a_upper: assert property (p_a_upper) else $error("port a upper nonzero"); // R1

  property p_e_lower;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_E && variant == PIO_VAR_LARGE)
        |=> rdata[3:0] == 4'h0;
  endproperty
  a_e_lower: assert property (p_e_lower) else $error("port e lower nonzero"); // R5

  property p_read_pins;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_B) |=> rdata == $past(pin_lv[1]);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read not pins"); // R8

  property p_keep_master_clear_reset;
    @(posedge ref_clk) (rst && !por) |=> $stable(latch_q);
  endproperty
  a_keep_master_clear_reset: assert property (p_keep_master_clear_reset) else $error("latch lost on reset"); // R13

  property p_por_clear;
    @(posedge ref_clk)
      (rst && por) |=> latch_q == {PIO_NPORT{PIO_LATCH_POR}};
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("latch not cleared"); // R13

  property p_rst_quiet;
    @(posedge ref_clk)
      rst |=> pin_out == 40'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pin driven after reset"); // R9

  // ==========================================
  // Checks on direction groups
  property p_dir_sel_ign;
    @(posedge ref_clk) disable iff (rst)
      (req.dir_ld && req.dir_sel > 3'h4) |=> $stable(dir_q);
  endproperty
  a_dir_sel_ign: assert property (p_dir_sel_ign) else $error("bad group loaded"); // R6

  property p_dir_hold;
    @(posedge ref_clk) disable iff (rst)
      !req.dir_ld |=> $stable(dir_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir changed unloaded"); // R6

  // Unimplemented pins must never drive, whatever the load value
  property p_a_oe;
    @(posedge ref_clk) disable iff (rst)
      pin_oe_n[7:4] == 4'hF;
  endproperty
  a_a_oe: assert property (p_a_oe) else $error("port a upper drives"); // R1

  property p_e_oe;
    @(posedge ref_clk) disable iff (rst)
      pin_oe_n[35:32] == 4'hF;
  endproperty
  a_e_oe: assert property (p_e_oe) else $error("port e lower drives"); // R5

  property p_small_c;
    @(posedge ref_clk) disable iff (rst)
      variant == PIO_VAR_SMALL |-> pin_oe_n[23:16] == 8'hFF;
  endproperty
  a_small_c: assert property (p_small_c) else $error("storage c drives"); // R3

  property p_small_de;
    @(posedge ref_clk) disable iff (rst)
      variant != PIO_VAR_LARGE |-> pin_oe_n[39:24] == 16'hFFFF;
  endproperty
  a_small_de: assert property (p_small_de) else $error("storage d e drives"); // R4

  // ==========================================
  // Checks on the read path
  property p_rvalid_rd;
    @(posedge ref_clk) disable iff (rst)
      req.rd |=> rvalid;
  endproperty
  a_rvalid_rd: assert property (p_rvalid_rd) else $error("rvalid missing"); // R8

  property p_rvalid_idle;
    @(posedge ref_clk) disable iff (rst)
      !req.rd |=> !rvalid;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("rvalid without read"); // R8

  property p_rdata_hold;
    @(posedge ref_clk) disable iff (rst)
      !req.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved"); // R8

  property p_c_pins;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_C && variant != PIO_VAR_SMALL)
        |=> rdata == $past(pin_lv[2]);
  endproperty
  a_c_pins: assert property (p_c_pins) else $error("port c read not pins"); // R3

  property p_gpr_hit;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_C && variant == PIO_VAR_SMALL) |-> gpr_hit;
  endproperty
  a_gpr_hit: assert property (p_gpr_hit) else $error("storage hit missing"); // R3

  property p_no_gpr_large;
    @(posedge ref_clk) disable iff (rst)
      variant == PIO_VAR_LARGE |-> !gpr_hit;
  endproperty
  a_no_gpr_large: assert property (p_no_gpr_large) else $error("storage hit on large"); // R4

  // Storage mode reads the whole byte, not the pins
  property p_gpr_c_read;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_C && variant == PIO_VAR_SMALL)
        |=> rdata == $past(latch_q[2]);
  endproperty
  a_gpr_c_read: assert property (p_gpr_c_read) else $error("storage c read wrong"); // R3

  property p_gpr_d_read;
    @(posedge ref_clk) disable iff (rst)
      (req.rd && req.addr == PIO_ADDR_D && variant != PIO_VAR_LARGE)
        |=> rdata == $past(latch_q[3]);
  endproperty
  a_gpr_d_read: assert property (p_gpr_d_read) else $error("storage d read wrong"); // R4

  // ==========================================
  // Checks on the output latches
  property p_a_mask;
    @(posedge ref_clk) disable iff (rst)
      (req.wr && req.addr == PIO_ADDR_A) |=> latch_q[0][7:4] == 4'h0;
  endproperty
  a_a_mask: assert property (p_a_mask) else $error("port a upper latched"); // R1

  property p_e_mask;
    @(posedge ref_clk) disable iff (rst)
      (req.wr && req.addr == PIO_ADDR_E && variant == PIO_VAR_LARGE)
        |=> latch_q[4][3:0] == 4'h0;
  endproperty
  a_e_mask: assert property (p_e_mask) else $error("port e lower latched"); // R5

  property p_hold_all;
    @(posedge ref_clk) disable iff (rst)
      !req.wr |=> $stable(latch_q);
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("latch changed unwritten"); // R11
endmodule

// *** tb/parallel_io_ports_tb.sv ***
// Testbench for the parallel I/O ports, largest and smallest variants.
// Assumes pio_top and the board model pio_board.
`timescale 1ns/100ps
module parallel_io_ports_tb;
  import pio_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  logic por = 1;
  pio_variant_t variant = PIO_VAR_LARGE;
  pio_req_t req = '0;
  logic [7:0] wreg = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic gpr_hit;
  logic gpr_exp = 1'b0;
  logic [39:0] pin_in;
  logic [39:0] pin_out;
  logic [39:0] pin_oe_n;
  logic [39:0] ext = {40{1'b1}};
  logic [39:0] hold_low = 40'h0;
  logic [7:0] exp_rd [5] = '{8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hF0};
  int err_count = 0;
  int check_count = 0;
  always #5 ref_clk = ~ref_clk;
  pio_top dut (.ref_clk(ref_clk), .rst(rst), .por(por), .variant(variant), .req(req),
    .wreg(wreg), .rdata(rdata), .rvalid(rvalid), .gpr_hit(gpr_hit), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pio_board board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext),
    .hold_low(hold_low), .pin_in(pin_in));
  // ==========================================
  // Access tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset(input logic p);
    rst = 1;
    por = p;
    cyc(8);
    rst = 0;
    cyc(1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    req.wr = 1;
    req.addr = a;
    req.wdata = d;
    cyc(1);
    req.wr = 0;
    cyc(1);
  endtask
  // Pins need a few cycles through the filter before a read
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    cyc(6);
    req.rd = 1;
    req.addr = a;
    #2;
    check(gpr_hit, gpr_exp);
    cyc(1);
    req.rd = 0;
    check(rvalid, 1'b1);
    check(rdata, exp);
    cyc(1);
    check(rvalid, 1'b0);
  endtask
  task automatic dirld(input logic [2:0] sel, input logic [7:0] v);
    req.dir_ld = 1;
    req.dir_sel = sel;
    wreg = v;
    cyc(1);
    req.dir_ld = 0;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    do_reset(1);
    check(pin_oe_n, {40{1'b1}});
    dirld(3'h5, 8'h00);
    check(pin_oe_n, {40{1'b1}});
    for (int i = 0; i < 5; i++) rd(5'(5 + i), exp_rd[i]);
    $display("test reset and reads done");
    wr(PIO_ADDR_B, 8'hA5);
    dirld(1, 8'h00);
    check(pin_out[15:8], 8'hA5);
    hold_low[8] = 1;
    rd(PIO_ADDR_B, 8'hA4);
    hold_low[8] = 0;
    dirld(2, 8'h5A);
    wr(PIO_ADDR_C, 8'h0F);
    check(pin_out[23:16], 8'h05);
    rd(PIO_ADDR_C, 8'h5F);
    check(pin_out[15:8], 8'hA5);
    $display("test per-pin drive done");
    for (int i = 0; i < 5; i++) dirld(3'(i), 8'h00);
    check(pin_oe_n, 40'h0F000000F0);
    for (int i = 0; i < 5; i++) wr(5'(5 + i), 8'h3C);
    do_reset(0);
    check(pin_oe_n, {40{1'b1}});
    for (int i = 0; i < 5; i++) dirld(3'(i), 8'h00);
    check(pin_out, 40'h303C3C3C0C);
    $display("test warm reset done");
    variant = PIO_VAR_SMALL;
    gpr_exp = 1'b1;
    do_reset(1);
    wr(PIO_ADDR_C, 8'hC3);
    wr(PIO_ADDR_D, 8'h96);
    dirld(2, 8'h00);
    rd(PIO_ADDR_C, 8'hC3);
    rd(PIO_ADDR_D, 8'h96);
    check(pin_oe_n[23:16], 8'hFF);
    $display("test storage variant done");
    report_and_stop;
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end
endmodule

// *** tb/pio_board.sv ***
// Board model standing on the forty port pins.
// Assumes pin_oe_n low means the port drives the pin.
`timescale 1ns/100ps
module pio_board (
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe_n,
  input wire logic [39:0] ext,
  input wire logic [39:0] hold_low,
  output logic [39:0] pin_in
);
  // ==========================================
  // Pin levels
  // driven pins follow port, board can win low
  assign pin_in = ~hold_low & ((~pin_oe_n & pin_out) | (pin_oe_n & ext));
endmodule
